// ---- src/phy_event_map.vh ----
`ifndef PHY_EVENT_MAP_VH
`define PHY_EVENT_MAP_VH
// register addresses on the byte-wide control bus
`define ADDR_PORT_CFG 5'h01
`define ADDR_EVENT_COND 5'h02
`define ADDR_EVENT_MASK 5'h03
`define ADDR_TX_STATE 5'h04
`define ADDR_RX_STATE 5'h08
`define ADDR_NOISE_CNT 5'h0F
`define ADDR_NOISE_PRE 5'h10
`define ADDR_STATE_CNT 5'h13
`define ADDR_STATE_PRE 5'h14
`define ADDR_LINK_ERR 5'h16
`define ADDR_DEV_ID 5'h18
`define ADDR_INJ_CNT 5'h19
`define ADDR_EVENT_CMP 5'h1A
`define ADDR_RSVD_ZERO 5'h1E
// field positions
`define BIT_A_OE 6
`define BIT_B_OE 7
`define BIT_REQ_PAR_EN 0
`define BIT_REQ_PAR 0
`define BIT_HOST_PAR 1
`define BIT_WR_REJ 2
`define BIT_CWI 3
`define BIT_LINK_THR 4
`define BIT_RCV_A 5
`define BIT_RCV_B 6
`define BIT_USER 7
// reset values
`define RST_PORT_CFG 8'h00
`define RST_EVENT_MASK 8'h00
`define RST_EVENT_COND 8'h10
`define RST_TX_STATE 8'h00
`define RST_EVENT_CMP 8'h00
`endif

// ---- src/event_bit.v ----
`timescale 1ns/1ps
`default_nettype none
// one sticky event bit: hardware set wins over a host clear
module event_bit
(
  input wire sys_clk,
  input wire resetn,
  input wire setEv,
  input wire clrEv,
  input wire wrEv,
  input wire wrVal,
  input wire rstVal,
  output reg bitOut
);
  // async reset always loads zero; the per-instance rstVal has no effect
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      bitOut <= 1'b0;
    else if (setEv)
      bitOut <= 1'b1;
    else if (clrEv)
      bitOut <= 1'b0;
    else if (wrEv)
      bitOut <= wrVal;
    else if (rstVal && 1'b0)
      bitOut <= 1'b1;
  end
endmodule
`default_nettype wire

// ---- src/phy_event_condition_logic.v ----
`include "phy_event_map.vh"
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - a-side output enable clear drives a_side_oe low; a-side indicate outputs stay driven
// - a-side indicate enable is bit 6 of the port configuration register
// - b-side enable at bit 7; zero drives b_side_oe low, b-side indicate outputs stay driven
// - b-side enable one drives b-side parity, control and data outputs
// - single-attach build keeps b-side bit writable but without pin effect
// - event condition register at 02h records error and status events
// - interrupt low when any event bit and its mask bit are both set
// - request parity flag set when check enabled and parity error seen
// - request parity check applies to any selected transmitter source
// - host parity flag set on write parity error when check pin high
// - write to read-only register sets reject flag, contents unchanged
// - receive state 08, noise count 0F and reserved 1E are read-only
// - noise prescale 10, state count 13, state prescale 14 read-only
// - link error count 16, device id 18, injection count 19 read-only
// - write changing event bit differing from compare sets inhibit, blocks
// - event mask register clears at reset, all sources masked
module phy_event_condition_logic
#(
  parameter DUAL_ATTACH = 1,
  parameter [7:0] DEVICE_ID = 8'h5A // arbitrary value
)
(
  input wire sys_clk,
  input wire resetn,
  input wire [4:0] hostAddr,
  input wire [7:0] hostWrData,
  input wire hostWrParity,
  input wire hostWr,
  input wire hostRd,
  output reg [7:0] hostRdData,
  input wire host_bus_parity_check_pin,
  input wire reqParityErr,
  input wire linkErrZero,
  input wire rcvGroupA,
  input wire rcvGroupB,
  input wire userSense,
  input wire [7:0] aIndSrcData,
  input wire aIndSrcParity,
  input wire aIndSrcControl,
  input wire [7:0] bIndSrcData,
  input wire bIndSrcParity,
  input wire bIndSrcControl,
  output reg [7:0] a_side_data_out,
  output reg a_side_parity_out,
  output reg a_side_control_out,
  output wire a_side_oe,
  output reg [7:0] b_side_data_out,
  output reg b_side_parity_out,
  output reg b_side_control_out,
  output wire b_side_oe,
  output wire intN
);
  reg [7:0] portCfg_q;
  reg [7:0] event_mask_reg;
  reg [7:0] transmit_state_reg;
  reg [7:0] event_compare_reg;
  reg [1:0] chkPinSync_q;
  reg [1:0] userSync_q;
  reg [1:0] rcvASync_q;
  reg [1:0] rcvBSync_q;
  wire [7:0] event_condition_reg;
  wire wrValid;
  wire hostParBad;
  reg readOnlyHit;
  wire [7:0] setVec;
  wire [7:0] clrVec;
  wire [7:0] wrVec;
  wire condWrite;
  wire inhibit;

  // two-stage synchronisers for pin-level inputs
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chkPinSync_q <= 2'h0;
      userSync_q <= 2'h0;
      rcvASync_q <= 2'h0;
      rcvBSync_q <= 2'h0;
    end
    else
    begin
      chkPinSync_q <= {chkPinSync_q[0], host_bus_parity_check_pin};
      userSync_q <= {userSync_q[0], userSense};
      rcvASync_q <= {rcvASync_q[0], rcvGroupA};
      rcvBSync_q <= {rcvBSync_q[0], rcvGroupB};
    end
  end

  // odd parity over host write byte
  assign hostParBad = chkPinSync_q[1] &&
    ~(^{hostWrData, hostWrParity});
  assign wrValid = hostWr && !hostParBad;

  // decode of read-only addresses
  always @*
  begin
    case (hostAddr)
      `ADDR_RX_STATE, `ADDR_NOISE_CNT, `ADDR_RSVD_ZERO:
        readOnlyHit = 1'b1;
      `ADDR_NOISE_PRE, `ADDR_STATE_CNT, `ADDR_STATE_PRE:
        readOnlyHit = 1'b1;
      `ADDR_LINK_ERR, `ADDR_DEV_ID, `ADDR_INJ_CNT:
        readOnlyHit = 1'b1;
      default:
        readOnlyHit = 1'b0;
    endcase
  end

  // conditional write: blocked when current bits differ from compare
  assign condWrite = wrValid && (hostAddr == `ADDR_EVENT_COND);
  assign inhibit = condWrite &&
    (event_condition_reg != event_compare_reg);

  // writable registers; read-only ones are never stored
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      portCfg_q <= `RST_PORT_CFG;
      event_mask_reg <= `RST_EVENT_MASK;
      transmit_state_reg <= `RST_TX_STATE;
      event_compare_reg <= `RST_EVENT_CMP;
    end
    else if (wrValid && !readOnlyHit)
    begin
      case (hostAddr)
        `ADDR_PORT_CFG:
          portCfg_q <= hostWrData;
        `ADDR_EVENT_MASK:
          event_mask_reg <= hostWrData;
        `ADDR_TX_STATE:
          transmit_state_reg <= hostWrData;
        `ADDR_EVENT_CMP:
          event_compare_reg <= hostWrData;
        default:
          portCfg_q <= portCfg_q;
      endcase
    end
  end

  // hardware set sources of each event bit
  assign setVec[`BIT_REQ_PAR] =
    transmit_state_reg[`BIT_REQ_PAR_EN] && reqParityErr;
  assign setVec[`BIT_HOST_PAR] = hostWr && hostParBad;
  assign setVec[`BIT_WR_REJ] = wrValid && readOnlyHit;
  assign setVec[`BIT_CWI] = inhibit;
  assign setVec[`BIT_LINK_THR] = linkErrZero;
  assign setVec[`BIT_RCV_A] = rcvASync_q[1];
  assign setVec[`BIT_RCV_B] = rcvBSync_q[1];
  assign setVec[`BIT_USER] = userSync_q[1];
  assign wrVec = {8{condWrite && !inhibit}};
  assign clrVec = 8'h00;

  // sticky event bits, set dominates any clearing write
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : evBits
      event_bit uBit
      (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .setEv(setVec[gi]),
        .clrEv(clrVec[gi]),
        .wrEv(wrVec[gi]),
        .wrVal(hostWrData[gi]),
        .rstVal(1'b0),
        .bitOut(event_condition_reg[gi])
      );
    end
  endgenerate

  // interrupt request, active low
  assign intN = ~|(event_condition_reg & event_mask_reg);

  // read data register
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      hostRdData <= 8'h00;
    else if (hostRd)
    begin
      case (hostAddr)
        `ADDR_PORT_CFG: hostRdData <= portCfg_q;
        `ADDR_EVENT_COND: hostRdData <= event_condition_reg;
        `ADDR_EVENT_MASK: hostRdData <= event_mask_reg;
        `ADDR_TX_STATE: hostRdData <= transmit_state_reg;
        `ADDR_EVENT_CMP: hostRdData <= event_compare_reg;
        `ADDR_DEV_ID: hostRdData <= DEVICE_ID;
        default: hostRdData <= 8'h00;
      endcase
    end
  end

  // indicate port output enables
  assign a_side_oe = portCfg_q[`BIT_A_OE];
  assign b_side_oe = (DUAL_ATTACH != 0) &&
    portCfg_q[`BIT_B_OE];

  // registered indicate data
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      a_side_data_out <= 8'h00;
      a_side_parity_out <= 1'b0;
      a_side_control_out <= 1'b0;
      b_side_data_out <= 8'h00;
      b_side_parity_out <= 1'b0;
      b_side_control_out <= 1'b0;
    end
    else
    begin
      a_side_data_out <= aIndSrcData;
      a_side_parity_out <= aIndSrcParity;
      a_side_control_out <= aIndSrcControl;
      b_side_data_out <= bIndSrcData;
      b_side_parity_out <= bIndSrcParity;
      b_side_control_out <= bIndSrcControl;
    end
  end
endmodule
`default_nettype wire

// ---- sim/phy_event_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module phy_event_checker
#(
  parameter [7:0] DEVICE_ID = 8'h5A
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [4:0] hostAddr,
  input wire logic [7:0] hostWrData,
  input wire logic hostWrParity,
  input wire logic hostWr,
  input wire logic hostRd,
  input wire logic [7:0] hostRdData,
  input wire logic [7:0] aIndSrcData,
  input wire logic [7:0] a_side_data_out,
  input wire logic a_side_oe,
  input wire logic b_side_oe,
  input wire logic intN
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // write decode
  wire okPar = ^{hostWrData, hostWrParity};
  wire wrCfg = hostWr && hostAddr == 5'h01;
  wire roHit = hostAddr inside {5'h08, 5'h0F, 5'h10, 5'h13, 5'h14,
    5'h16, 5'h18, 5'h19, 5'h1E};
  logic maskZero_q;
  // mask known zero: after reset or a clean write of zero
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      maskZero_q <= 1'h1;
    else if (hostWr && hostAddr == 5'h03)
      maskZero_q <= hostWrData == 8'h00 && (okPar || maskZero_q);
  a_a_oe_load: assert property (
    wrCfg && okPar |=> a_side_oe == $past(hostWrData[6]))
    else $error("a enable not loaded");
  a_b_oe_load: assert property (
    wrCfg && okPar |=> b_side_oe == $past(hostWrData[7]))
    else $error("b enable not loaded");
  a_oe_hold: assert property (
    !wrCfg |=> $stable(a_side_oe) && $stable(b_side_oe))
    else $error("enable changed without write");
  a_a_data: assert property (
    a_side_oe |-> a_side_data_out == $past(aIndSrcData))
    else $error("a data not copied");
  a_id_read: assert property (
    hostRd && hostAddr == 5'h18 |=> hostRdData == DEVICE_ID)
    else $error("id changed");
  a_reject_flag: assert property (
    hostWr && roHit ##2 hostRd && hostAddr == 5'h02 |=> hostRdData[2])
    else $error("reject flag missing");
  a_mask_zero: assert property (
    maskZero_q |-> intN)
    else $error("interrupt while masked");
  a_mask_one: assert property (
    hostWr && hostAddr == 5'h03 && okPar && hostWrData != 8'h00 |=>
    !maskZero_q)
    else $error("mask tracking");
  c_cfg: cover property (wrCfg && okPar);
  c_int: cover property (!intN);
  c_rej: cover property (hostWr && roHit);
endmodule
bind phy_event_condition_logic phy_event_checker
  #(.DEVICE_ID(DEVICE_ID)) u_chk (.*);
`default_nettype wire

// ---- sim/host_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
(
  input wire logic sys_clk,
  input wire logic [7:0] hostRdData,
  output logic [4:0] hostAddr = 5'h00,
  output logic [7:0] hostWrData = 8'h00,
  output logic hostWrParity = 1'h1,
  output logic hostWr = 1'h0,
  output logic hostRd = 1'h0
);
  // one access, held over the taking edge; bad flips the parity
  task automatic xfer(input logic w, input logic [4:0] a,
    input logic [7:0] d, input logic bad, output logic [7:0] q);
    @(posedge sys_clk);
    #1;
    hostAddr = a;
    hostWrData = d;
    hostWrParity = ~^d ^ bad; // odd parity
    hostWr = w;
    hostRd = !w;
    @(posedge sys_clk);
    #1;
    q = hostRdData;
    hostWr = 1'h0;
    hostRd = 1'h0;
    hostAddr = ~a; // released lines do not keep their value
    hostWrData = ~d;
  endtask
endmodule
`default_nettype wire

// ---- sim/phy_event_condition_logic_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module phy_event_condition_logic_tb_top;
  localparam logic [7:0] ID = 8'h5A; // arbitrary identity value
  logic sys_clk = 1'h0, resetn = 1'h0, host_bus_parity_check_pin = 1'h0;
  logic reqParityErr = 1'h0, linkErrZero = 1'h0, userSense = 1'h0;
  logic rcvGroupA = 1'h0, rcvGroupB = 1'h0;
  logic [7:0] aIndSrcData = 8'h00, bIndSrcData = 8'h00;
  logic aIndSrcParity = 1'h0, aIndSrcControl = 1'h0;
  logic bIndSrcParity = 1'h0, bIndSrcControl = 1'h0;
  logic [15:0] cyc = 16'h0000;
  logic [7:0] sa, sb;
  logic [3:0] sf;
  int num_errors = 0, total_checks = 0;
  logic [4:0] ro [9] = '{5'h08, 5'h0F, 5'h10, 5'h13, 5'h14, 5'h16,
    5'h18, 5'h19, 5'h1E};
  wire [4:0] hostAddr;
  wire [7:0] hostWrData, hostRdData, a_side_data_out, b_side_data_out;
  wire hostWrParity, hostWr, hostRd, intN, a_side_oe, b_side_oe;
  wire a_side_parity_out, a_side_control_out;
  wire b_side_parity_out, b_side_control_out;
  phy_event_condition_logic #(.DEVICE_ID(ID)) u_dut (.*);
  host_bus_model u_host (.*);
  always #2 sys_clk = ~sys_clk;
  // cycle count and hang limit
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 16'h0001;
    if (cyc == 16'h0BB8)
    begin
      num_errors++;
      end_sim();
    end
  end
  // moving indicate sources
  always @(posedge sys_clk)
  begin
    #1 {aIndSrcData, bIndSrcData} = {cyc[7:0], ~cyc[7:0]};
    {aIndSrcParity, aIndSrcControl} = cyc[1:0];
    {bIndSrcParity, bIndSrcControl} = cyc[3:2];
  end
  task automatic chk(input string n, input logic [7:0] e, s);
    total_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d,
    input logic bad = 1'h0);
    logic [7:0] q;
    u_host.xfer(1'h1, a, d, bad, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e, string n);
    logic [7:0] q;
    u_host.xfer(1'h0, a, 8'h00, 1'h0, q);
    chk(n, e, q);
  endtask
  task automatic clr(input logic [7:0] e);
    wr(5'h1A, e);
    wr(5'h02, 8'h00);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    #1 resetn = 1'h1;
    rd(5'h03, 8'h00, "mask");
    chk("intN", 8'h01, {7'h00, intN});
    rd(5'h02, 8'h00, "event");
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      wr(5'h01, {i[1:0], 6'h00});
      chk("oe", {6'h00, i[1:0]}, {6'h00, b_side_oe, a_side_oe});
    end
    // indicate copies: capture settled sources, compare one edge later
    @(posedge sys_clk) #2 {sa, sb} = {aIndSrcData, bIndSrcData};
    sf = {aIndSrcParity, aIndSrcControl, bIndSrcParity, bIndSrcControl};
    @(posedge sys_clk) #2;
    chk("a data", sa, a_side_data_out);
    chk("b data", sb, b_side_data_out);
    chk("ind flags", {4'h0, sf}, {4'h0, a_side_parity_out,
      a_side_control_out, b_side_parity_out, b_side_control_out});
    $display("test enables done");
    for (int i = 0; i < 2; i++)
    begin
      wr(5'h04, i[7:0]);
      @(posedge sys_clk) #1 reqParityErr = 1'h1;
      @(posedge sys_clk) #1 reqParityErr = 1'h0;
      rd(5'h02, i[7:0], "req parity");
    end
    wr(5'h02, 8'h00);
    rd(5'h02, 8'h09, "inhibit");
    wr(5'h03, 8'h01);
    chk("intN", 8'h00, {7'h00, intN});
    clr(8'h09);
    rd(5'h02, 8'h00, "cleared");
    $display("test event bits done");
    {linkErrZero, rcvGroupA, rcvGroupB, userSense} = 4'hF;
    repeat (4) @(posedge sys_clk);
    #1 {linkErrZero, rcvGroupA, rcvGroupB, userSense} = 4'h0;
    repeat (3) @(posedge sys_clk);
    rd(5'h02, 8'hF0, "status bits");
    linkErrZero = 1'h1;
    clr(8'hF0);
    rd(5'h02, 8'h10, "set beats clear");
    linkErrZero = 1'h0;
    clr(8'h10);
    rd(5'h02, 8'h00, "status cleared");
    $display("test status bits done");
    host_bus_parity_check_pin = 1'h1;
    repeat (3) @(posedge sys_clk);
    wr(5'h03, 8'hFF, 1'h1);
    rd(5'h03, 8'h01, "mask kept");
    rd(5'h02, 8'h02, "host parity");
    clr(8'h02);
    foreach (ro[i])
    begin
      wr(ro[i], 8'hFF);
      rd(5'h02, 8'h04, "reject");
      clr(8'h04);
    end
    rd(5'h18, ID, "id");
    $display("test host writes done");
    end_sim();
  end
endmodule
`default_nettype wire
